/* File: pkg/fpuex_pkg.sv */
/*
 Constants, encodings and default result patterns of the FPU exception
 reporting unit. Assumes the arithmetic datapath classifies operands and
 flags raw result conditions for each completing operation.
*/
// Behaviour
// - Enabled exception sets cause and requests trap
// - Disabled exception writes default, sets cause, flag
// - Cause, enable, flag for five standard exceptions
// - Unimplemented cause has no enable, always traps
// - Trap reports FP code; cause bits refine it
// - Flag set only when disabled; software clears it
// - Defaults: quiet NaN, signed infinity, rounded result
// - Overflow default follows rounding mode
// - Underflow default follows rounding mode
// - Inexact on accuracy loss, overflow, flushed underflow
// - Overflow always raises overflow and inexact together
// - Integer convert overflow reports unimplemented, not invalid
// - Signaling NaN arithmetic operand raises invalid
// - Underflow flushes only if disabled and flush set
// - Invalid for listed inf, zero, sqrt, compare cases
// - Compare or float convert of signaling NaN invalid
// - Trap leaves destination and sources untouched
// - No trap: rounded or default result is written, except for compare
// - Denormal or quiet NaN operand raises unimplemented, except in move and compare
// - Divide by zero for finite nonzero dividend
package fpuex_pkg;

    localparam int EXC_W = 5;
    localparam int CAUSE_W = 6;
    localparam int DATA_W = 64;
    localparam int CODE_W = 5;

    localparam int BIT_I = 0;
    localparam int BIT_U = 1;
    localparam int BIT_O = 2;
    localparam int BIT_Z = 3;
    localparam int BIT_V = 4;
    localparam int BIT_E = 5;

    localparam logic [CAUSE_W-1:0] RST_CAUSE = 6'h00;
    localparam logic [EXC_W-1:0] RST_ENABLE = 5'h00;
    localparam logic [EXC_W-1:0] RST_FLAG = 5'h00;
    localparam logic RST_FLUSH = 1'b0;
    localparam logic [CODE_W-1:0] CODE_NONE = 5'h00;

    typedef enum logic [1:0] {
        round_nearest = 2'b00,
        round_toward_zero = 2'b01,
        round_up_positive = 2'b10,
        round_down_negative = 2'b11
    } fpuex_rmode_t;

    typedef enum logic [3:0] {
        op_add = 4'b0000,
        op_sub = 4'b0001,
        op_mul = 4'b0010,
        op_div = 4'b0011,
        op_sqrt = 4'b0100,
        op_abs = 4'b0101,
        op_neg = 4'b0110,
        op_mov = 4'b0111,
        op_cmp = 4'b1000,
        op_cvt_fp = 4'b1001,
        op_cvt_int = 4'b1010,
        op_reserved = 4'b1011
    } fpuex_op_t;

    localparam logic [DATA_W-1:0] ZERO_VAL = 64'h0000_0000_0000_0000;
    localparam logic [DATA_W-1:0] SGL_SIGN = 64'h0000_0000_8000_0000;
    localparam logic [DATA_W-1:0] DBL_SIGN = 64'h8000_0000_0000_0000;
    localparam logic [DATA_W-1:0] SGL_QNAN = 64'h0000_0000_7fbf_ffff;
    localparam logic [DATA_W-1:0] DBL_QNAN = 64'h7ff7_ffff_ffff_ffff;
    localparam logic [DATA_W-1:0] SGL_INF = 64'h0000_0000_7f80_0000;
    localparam logic [DATA_W-1:0] DBL_INF = 64'h7ff0_0000_0000_0000;
    localparam logic [DATA_W-1:0] SGL_MAXN = 64'h0000_0000_7f7f_ffff;
    localparam logic [DATA_W-1:0] DBL_MAXN = 64'h7fef_ffff_ffff_ffff;
    localparam logic [DATA_W-1:0] SGL_MINN = 64'h0000_0000_0080_0000;
    localparam logic [DATA_W-1:0] DBL_MINN = 64'h0010_0000_0000_0000;

endpackage

/* File: logic/fpuex_unit.sv */
/*
 FPU exception reporting unit: classifies each completing operation,
 updates the cause, enable and flag state, and either raises a trap to the
 CPU or, except for a compare, writes the rounded or default result. Assumes operand class bits, raw result
 conditions and the rounded result arrive with op_done, and that the
 control register write port is driven by the move to control instruction.
*/
`timescale 1ns/1ps
module fpuex_unit
    import fpuex_pkg::*;
#(
    parameter logic [CODE_W-1:0] FP_EXC_CODE = 5'h0f
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Completing operation
    input wire logic op_done,
    input wire fpuex_op_t op_kind,
    input wire logic fmt_double,
    input wire logic cmp_ordered_pred,
    // Operand A class
    input wire logic opa_sign,
    input wire logic opa_zero,
    input wire logic opa_inf,
    input wire logic opa_snan,
    input wire logic opa_qnan,
    input wire logic opa_denorm,
    // Operand B class
    input wire logic opb_sign,
    input wire logic opb_zero,
    input wire logic opb_inf,
    input wire logic opb_snan,
    input wire logic opb_qnan,
    input wire logic opb_denorm,
    // Raw result conditions
    input wire logic res_inexact,
    input wire logic res_overflow,
    input wire logic res_underflow,
    input wire logic res_sign,
    input wire logic cvt_int_range_err,
    input wire logic [DATA_W-1:0] res_value,
    // Control register write
    input wire logic move_to_fp_control,
    input wire logic [CAUSE_W-1:0] ctl_wr_cause,
    input wire logic [EXC_W-1:0] ctl_wr_enable,
    input wire logic [EXC_W-1:0] ctl_wr_flag,
    input wire logic ctl_wr_flush,
    input wire fpuex_rmode_t ctl_wr_rmode,
    // Control register state
    output logic [CAUSE_W-1:0] cause_bits,
    output logic [EXC_W-1:0] enable_bits,
    output logic [EXC_W-1:0] flag_bits,
    output logic flush_subnormal_mode,
    output fpuex_rmode_t round_mode,
    // Destination write
    output logic dest_we,
    output logic [DATA_W-1:0] dest_data,
    // Trap toward the CPU
    output logic fp_irq,
    output logic fp_trap_taken,
    output logic [CODE_W-1:0] fp_exception_code
);

    logic [CAUSE_W-1:0] cause_ff;
    logic [EXC_W-1:0] enable_ff;
    logic [EXC_W-1:0] flag_ff;
    logic flush_ff;
    fpuex_rmode_t rmode_ff;
    logic dest_we_ff;
    logic [DATA_W-1:0] dest_data_ff;
    logic irq_ff;
    logic trap_ff;
    logic [CODE_W-1:0] code_ff;

    logic [CAUSE_W-1:0] nxt_cause;
    logic [EXC_W-1:0] nxt_flag;
    logic [CAUSE_W-1:0] op_cause;
    logic op_trap;
    logic op_writes;
    logic [DATA_W-1:0] nxt_dest_data;
    logic [EXC_W-1:0] irq_enable;

    logic is_arith;
    logic any_snan;
    logic any_nan;
    logic src_unimpl;
    logic cvt_unimpl;
    logic inv_addsub;
    logic inv_mul;
    logic inv_div;
    logic inv_sqrt;
    logic inv_cmp;
    logic invalid;
    logic divzero;
    logic flush_ok;
    logic src_exc;

    // Picks the single or double precision form of a constant.
    function automatic logic [DATA_W-1:0] fmt_pick(
        input logic dbl,
        input logic [DATA_W-1:0] sgl_val,
        input logic [DATA_W-1:0] dbl_val
    );
        fmt_pick = dbl ? dbl_val : sgl_val;
    endfunction

    // Applies a sign to a magnitude pattern of the chosen format.
    function automatic logic [DATA_W-1:0] signed_val(
        input logic dbl,
        input logic neg,
        input logic [DATA_W-1:0] mag
    );
        signed_val = neg ? (mag | fmt_pick(dbl, SGL_SIGN, DBL_SIGN)) : mag;
    endfunction

    // Operand classification shared by the detectors below.
    always_comb
    begin
        is_arith = (op_kind == op_add) || (op_kind == op_sub) || (op_kind == op_mul) ||
                   (op_kind == op_div) || (op_kind == op_sqrt) || (op_kind == op_abs) ||
                   (op_kind == op_neg);
        any_snan = opa_snan || opb_snan;
        any_nan = any_snan || opa_qnan || opb_qnan;
        op_writes = (op_kind != op_cmp) && (op_kind != op_reserved);
    end

    // Source operands and conversions that the hardware hands to software.
    always_comb
    begin
        src_unimpl = 1'b0;
        cvt_unimpl = 1'b0;
        case (op_kind)
            op_cmp, op_mov:
            begin
                src_unimpl = 1'b0;
            end
            op_reserved:
            begin
                src_unimpl = 1'b1;
            end
            op_abs, op_neg, op_cvt_fp, op_cvt_int, op_sqrt:
            begin
                src_unimpl = opa_denorm || opa_qnan;
            end
            default:
            begin
                src_unimpl = opa_denorm || opb_denorm || opa_qnan || opb_qnan;
            end
        endcase
        if (op_kind == op_cvt_int)
        begin
            cvt_unimpl = cvt_int_range_err || opa_inf || opa_snan || opa_qnan;
        end
    end

    // Invalid operation detection.
    always_comb
    begin
        inv_addsub = 1'b0;
        inv_mul = 1'b0;
        inv_div = 1'b0;
        inv_sqrt = 1'b0;
        inv_cmp = 1'b0;
        case (op_kind)
            op_add:
            begin
                inv_addsub = opa_inf && opb_inf && (opa_sign != opb_sign);
            end
            op_sub:
            begin
                inv_addsub = opa_inf && opb_inf && (opa_sign == opb_sign);
            end
            op_mul:
            begin
                inv_mul = (opa_zero && opb_inf) || (opa_inf && opb_zero);
            end
            op_div:
            begin
                inv_div = (opa_zero && opb_zero) || (opa_inf && opb_inf);
            end
            op_sqrt:
            begin
                inv_sqrt = opa_sign && !opa_zero && !opa_snan && !opa_qnan;
            end
            op_cmp:
            begin
                inv_cmp = (cmp_ordered_pred && any_nan) || any_snan;
            end
            default:
            begin
                inv_cmp = 1'b0;
            end
        endcase
        invalid = inv_addsub || inv_mul || inv_div || inv_sqrt || inv_cmp ||
                  (is_arith && any_snan) ||
                  ((op_kind == op_cvt_fp) && opa_snan);
    end

    // Divide by zero needs a finite nonzero dividend.
    always_comb
    begin
        divzero = (op_kind == op_div) && opb_zero && !opa_zero && !opa_inf &&
                  !opa_snan && !opa_qnan;
    end

    // Builds the cause set of the completing operation.
    always_comb
    begin
        op_cause = RST_CAUSE;
        flush_ok = flush_ff && !enable_ff[BIT_U] && !enable_ff[BIT_I];
        src_exc = invalid || divzero;
        if (src_unimpl || cvt_unimpl)
        begin
            op_cause[BIT_E] = 1'b1;
        end
        else if (src_exc)
        begin
            op_cause[BIT_V] = invalid;
            op_cause[BIT_Z] = divzero && !invalid;
        end
        else
        begin
            if (res_overflow)
            begin
                op_cause[BIT_O] = 1'b1;
                op_cause[BIT_I] = 1'b1;
            end
            if (res_underflow)
            begin
                if (flush_ok)
                begin
                    op_cause[BIT_U] = 1'b1;
                    op_cause[BIT_I] = 1'b1;
                end
                else
                begin
                    op_cause[BIT_E] = 1'b1;
                end
            end
            if (res_inexact && !op_cause[BIT_E])
            begin
                op_cause[BIT_I] = 1'b1;
            end
        end
        // The unimplemented cause cannot be masked, so it always traps.
        op_trap = op_cause[BIT_E] || ((op_cause[EXC_W-1:0] & enable_ff) != RST_ENABLE);
    end

    // Default result selection for an operation that does not trap.
    always_comb
    begin
        nxt_dest_data = res_value;
        if (op_cause[BIT_V])
        begin
            nxt_dest_data = fmt_pick(fmt_double, SGL_QNAN, DBL_QNAN);
        end
        else if (op_cause[BIT_Z])
        begin
            nxt_dest_data = signed_val(fmt_double, opa_sign ^ opb_sign,
                                       fmt_pick(fmt_double, SGL_INF, DBL_INF));
        end
        else if (op_cause[BIT_O])
        begin
            case (rmode_ff)
                round_nearest:
                begin
                    nxt_dest_data = signed_val(fmt_double, res_sign,
                                               fmt_pick(fmt_double, SGL_INF, DBL_INF));
                end
                round_toward_zero:
                begin
                    nxt_dest_data = signed_val(fmt_double, res_sign,
                                               fmt_pick(fmt_double, SGL_MAXN, DBL_MAXN));
                end
                round_up_positive:
                begin
                    nxt_dest_data = res_sign ?
                        signed_val(fmt_double, 1'b1, fmt_pick(fmt_double, SGL_MAXN, DBL_MAXN)) :
                        fmt_pick(fmt_double, SGL_INF, DBL_INF);
                end
                default:
                begin
                    nxt_dest_data = res_sign ?
                        signed_val(fmt_double, 1'b1, fmt_pick(fmt_double, SGL_INF, DBL_INF)) :
                        fmt_pick(fmt_double, SGL_MAXN, DBL_MAXN);
                end
            endcase
        end
        else if (op_cause[BIT_U])
        begin
            case (rmode_ff)
                round_nearest, round_toward_zero:
                begin
                    nxt_dest_data = signed_val(fmt_double, res_sign, ZERO_VAL);
                end
                round_up_positive:
                begin
                    nxt_dest_data = res_sign ? ZERO_VAL :
                        fmt_pick(fmt_double, SGL_MINN, DBL_MINN);
                end
                default:
                begin
                    nxt_dest_data = res_sign ?
                        signed_val(fmt_double, 1'b1, fmt_pick(fmt_double, SGL_MINN, DBL_MINN)) :
                        ZERO_VAL;
                end
            endcase
        end
    end

    // Next cause and flag values; hardware sets win over a software write.
    always_comb
    begin
        nxt_cause = cause_ff;
        nxt_flag = flag_ff;
        // Pending causes are judged against the enables in force after this edge.
        irq_enable = move_to_fp_control ? ctl_wr_enable : enable_ff;
        if (move_to_fp_control)
        begin
            nxt_cause = ctl_wr_cause;
            nxt_flag = ctl_wr_flag;
        end
        if (op_done)
        begin
            nxt_cause = op_cause;
            nxt_flag = nxt_flag | (op_cause[EXC_W-1:0] & ~enable_ff);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cause_ff <= RST_CAUSE;
            flag_ff <= RST_FLAG;
        end
        else
        begin
            cause_ff <= nxt_cause;
            flag_ff <= nxt_flag;
        end
    end

    // Enables, flush mode and rounding mode change only by software.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_ff <= RST_ENABLE;
            flush_ff <= RST_FLUSH;
            rmode_ff <= round_nearest;
        end
        else if (move_to_fp_control)
        begin
            enable_ff <= ctl_wr_enable;
            flush_ff <= ctl_wr_flush;
            rmode_ff <= ctl_wr_rmode;
        end
    end

    // Destination write; a trapping operation leaves it untouched.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dest_we_ff <= 1'b0;
            dest_data_ff <= ZERO_VAL;
        end
        else
        begin
            dest_we_ff <= op_done && op_writes && !op_trap;
            if (op_done && op_writes && !op_trap)
            begin
                dest_data_ff <= nxt_dest_data;
            end
        end
    end

    // Interrupt request stays up while an enabled or unimplemented cause is pending.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_ff <= 1'b0;
            trap_ff <= 1'b0;
            code_ff <= CODE_NONE;
        end
        else
        begin
            // A trap in this cycle keeps the request up even if a same-cycle write drops its enable.
            irq_ff <= (op_done && op_trap) || nxt_cause[BIT_E] ||
                      ((nxt_cause[EXC_W-1:0] & irq_enable) != RST_ENABLE);
            trap_ff <= op_done && op_trap;
            if (op_done && op_trap)
            begin
                code_ff <= FP_EXC_CODE;
            end
            else if (op_done)
            begin
                code_ff <= CODE_NONE;
            end
        end
    end

    assign cause_bits = cause_ff;
    assign enable_bits = enable_ff;
    assign flag_bits = flag_ff;
    assign flush_subnormal_mode = flush_ff;
    assign round_mode = rmode_ff;
    assign dest_we = dest_we_ff;
    assign dest_data = dest_data_ff;
    assign fp_irq = irq_ff;
    assign fp_trap_taken = trap_ff;
    assign fp_exception_code = code_ff;

endmodule // fpuex_unit

/* File: tb/fpuex_cpu_model.sv */
/*
 Behavioural model of the CPU side that receives FPU traps.
 Assumes it shares sys_clk and rst_n with the exception unit.
*/
`timescale 1ns/1ps
module fpuex_cpu_model
    import fpuex_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Trap from the FPU
    input wire logic fp_trap_taken,
    input wire logic [CODE_W-1:0] fp_exception_code,
    // Recorded exception code
    output logic [CODE_W-1:0] cpu_cause_ff
);
    // The CPU cause register latches the FP code on each taken trap.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cpu_cause_ff <= '0;
        else if (fp_trap_taken)
            cpu_cause_ff <= fp_exception_code;
    end
endmodule // fpuex_cpu_model

/* File: tb/fpuex_unit_checker.sv */
/*
 Concurrent checks on the ports of the FPU exception unit.
 Assumes one clock domain and the bind statement at the foot.
*/
`timescale 1ns/1ps
module fpuex_unit_checker
    import fpuex_pkg::*;
#(
    parameter logic [CODE_W-1:0] FP_EXC_CODE = 5'h0f
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Operation
    input wire logic op_done,
    input wire fpuex_op_t op_kind,
    input wire logic opa_snan,
    input wire logic opb_qnan,
    input wire logic opb_denorm,
    input wire logic res_overflow,
    // Control write
    input wire logic move_to_fp_control,
    input wire logic [CAUSE_W-1:0] ctl_wr_cause,
    // Outputs
    input wire logic [CAUSE_W-1:0] cause_bits,
    input wire logic [EXC_W-1:0] enable_bits,
    input wire logic [EXC_W-1:0] flag_bits,
    input wire logic dest_we,
    input wire logic fp_irq,
    input wire logic fp_trap_taken,
    input wire logic [CODE_W-1:0] fp_exception_code
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    trap_no_dest_a: assert property (fp_trap_taken |-> !dest_we)
        else $error("destination written on a trap");
    trap_code_a: assert property (fp_trap_taken |-> fp_irq && fp_exception_code == FP_EXC_CODE)
        else $error("trap without irq or code");
    unimpl_trap_a: assert property (op_done ##1 cause_bits[BIT_E] |-> fp_trap_taken)
        else $error("unimplemented cause without trap");
    ovf_pair_a: assert property (op_done && res_overflow |=> cause_bits[BIT_O] == cause_bits[BIT_I])
        else $error("overflow without inexact");
    one_outcome_a: assert property (op_done && !(op_kind inside {op_cmp, op_reserved})
        |=> dest_we ^ fp_trap_taken)
        else $error("neither or both of write and trap");
    flag_sticky_a: assert property (!move_to_fp_control |=> (flag_bits & $past(flag_bits)) == $past(flag_bits))
        else $error("flag dropped without write");
    flag_source_a: assert property (op_done && !move_to_fp_control
        |=> (flag_bits & ~$past(flag_bits) & ~(cause_bits[EXC_W-1:0] & ~enable_bits)) == 5'h00)
        else $error("flag set for enabled or absent cause");
    snan_inv_a: assert property (op_done && opa_snan && op_kind inside {op_add, op_mul, op_abs, op_cmp}
        && !opb_qnan && !opb_denorm |=> cause_bits[BIT_V])
        else $error("signaling NaN not invalid");
    irq_clear_a: assert property (move_to_fp_control && ctl_wr_cause == 6'h00 && !op_done |=> !fp_irq)
        else $error("irq after cause cleared");
    irq_hold_a: assert property (fp_irq && !move_to_fp_control && !op_done |=> fp_irq)
        else $error("irq dropped by itself");

    cover property (fp_trap_taken);
    cover property (op_done && res_overflow);
    cover property (dest_we && flag_bits != 5'h00);
endmodule // fpuex_unit_checker

bind fpuex_unit fpuex_unit_checker #(.FP_EXC_CODE(FP_EXC_CODE)) chk (.*);

/* File: tb/fpuex_unit_tb_top.sv */
/*
 Self-checking testbench of the FPU exception unit.
 Assumes a 10 MHz clock and answers one cycle after each request.
*/
`timescale 1ns/1ps
module fpuex_unit_tb_top
    import fpuex_pkg::*;
;
    localparam logic [CODE_W-1:0] TB_CODE = 5'h0f;
    logic sys_clk, rst_n, op_done, fmt_double, cmp_ordered_pred;
    fpuex_op_t op_kind;
    logic opa_sign, opa_zero, opa_inf, opa_snan, opa_qnan, opa_denorm;
    logic opb_sign, opb_zero, opb_inf, opb_snan, opb_qnan, opb_denorm;
    logic res_inexact, res_overflow, res_underflow, res_sign, cvt_int_range_err;
    logic [DATA_W-1:0] res_value, dest_data, xp, msk;
    logic move_to_fp_control, ctl_wr_flush, dest_we, fp_irq, fp_trap_taken, flush_subnormal_mode;
    logic [CAUSE_W-1:0] ctl_wr_cause, cause_bits;
    logic [EXC_W-1:0] ctl_wr_enable, ctl_wr_flag, enable_bits, flag_bits;
    fpuex_rmode_t ctl_wr_rmode, round_mode;
    logic [CODE_W-1:0] fp_exception_code, cpu_cause;
    int compares, miscompares;

    fpuex_unit #(.FP_EXC_CODE(TB_CODE)) dut (.*);
    fpuex_cpu_model cpu (.sys_clk(sys_clk), .rst_n(rst_n), .fp_trap_taken(fp_trap_taken),
        .fp_exception_code(fp_exception_code), .cpu_cause_ff(cpu_cause));

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk_v(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_st(input logic t, input logic w, input logic i, input logic [5:0] c);
        chk_v(64'({fp_trap_taken, dest_we, fp_irq, cause_bits}), 64'({t, w, i, c}));
    endtask

    task automatic clr;
        {opa_sign, opa_zero, opa_inf, opa_snan, opa_qnan, opa_denorm, cmp_ordered_pred} = '0;
        {opb_sign, opb_zero, opb_inf, opb_snan, opb_qnan, opb_denorm} = '0;
        {res_inexact, res_overflow, res_underflow, res_sign, cvt_int_range_err} = '0;
        res_value = 64'h0;
        fmt_double = 1'b1;
        op_kind = op_add;
    endtask

    task automatic fire;
        @(posedge sys_clk);
        #1 op_done = 1'b1;
        @(posedge sys_clk);
        #1 op_done = 1'b0;
    endtask

    task automatic wr(input logic [5:0] c, input logic [4:0] e, input logic fl, input fpuex_rmode_t rm);
        @(posedge sys_clk);
        #1 move_to_fp_control = 1'b1;
        ctl_wr_cause = c;
        ctl_wr_enable = e;
        ctl_wr_flag = 5'h00;
        ctl_wr_flush = fl;
        ctl_wr_rmode = rm;
        @(posedge sys_clk);
        #1 move_to_fp_control = 1'b0;
        clr;
    endtask

    task automatic t_reset;
        chk_st(1'b0, 1'b0, 1'b0, 6'h00);
        chk_v(64'({enable_bits, flag_bits, flush_subnormal_mode, round_mode, fp_exception_code}), 64'h0);
    endtask

    task automatic t_invalid;
        fpuex_op_t ops [10] = '{op_add, op_mul, op_div, op_div, op_sqrt,
                                op_cmp, op_abs, op_cvt_fp, op_cmp, op_sub};
        wr(6'h00, 5'h00, 1'b0, round_nearest);
        for (int i = 0; i < 10; i++)
        begin
            clr;
            fmt_double = (i != 1);
            op_kind = ops[i];
            case (i)
                0: {opa_inf, opb_inf, opb_sign} = 3'h7;
                1: {opa_zero, opb_inf} = 2'h3;
                2: {opa_zero, opb_zero} = 2'h3;
                4: opa_sign = 1'b1;
                5: {opb_qnan, cmp_ordered_pred} = 2'h3;
                6, 7, 8: opa_snan = 1'b1;
                default: {opa_inf, opb_inf} = 2'h3;
            endcase
            fire;
            chk_st(1'b0, op_kind != op_cmp, 1'b0, 6'h10);
            if (op_kind != op_cmp)
                chk_v(dest_data, (i == 1) ? SGL_QNAN : DBL_QNAN);
        end
        chk_v(64'(flag_bits), 64'h10);
        wr(6'h00, 5'h10, 1'b0, round_nearest);
        {opa_inf, opb_inf, opb_sign} = 3'h7;
        fire;
        chk_st(1'b1, 1'b0, 1'b1, 6'h10);
        chk_v(64'(flag_bits), 64'h00);
        // The CPU model latches the code one edge after the trap pulse.
        @(posedge sys_clk);
        #1;
        chk_v(64'({fp_exception_code, cpu_cause}), 64'({TB_CODE, TB_CODE}));
        wr(6'h00, 5'h10, 1'b0, round_nearest);
        chk_st(1'b0, 1'b0, 1'b0, 6'h00);
    endtask

    task automatic t_range;
        for (int k = 0; k < 16; k++)
        begin
            wr(6'h00, 5'h00, k[3], fpuex_rmode_t'(k[2:1]));
            {res_overflow, res_underflow} = k[3] ? 2'h1 : 2'h2;
            op_kind = op_mul;
            {res_inexact, res_sign} = {1'b1, k[0]};
            fire;
            xp = k[0] ? DBL_SIGN : ZERO_VAL;
            msk = 64'hffff_ffff_ffff_ffff;
            if (!k[3])
                xp |= (k[2:1] == 2'h1 || k[2:1] == {1'b1, ~k[0]}) ? DBL_MAXN : DBL_INF;
            else if (k[2:1] == {1'b1, k[0]})
                xp |= DBL_MINN;
            else if (k[2])
                msk = ~DBL_SIGN;
            chk_st(1'b0, 1'b1, 1'b0, k[3] ? 6'h03 : 6'h05);
            chk_v(dest_data & msk, xp & msk);
            chk_v(64'({round_mode, flush_subnormal_mode, enable_bits}), 64'({k[2:1], k[3], 5'h00}));
        end
        for (int k = 0; k < 3; k++)
        begin
            wr(6'h00, (k == 0) ? 5'h04 : 5'h02, k[1], round_nearest);
            {res_overflow, res_underflow, res_inexact} = (k == 0) ? 3'h5 : 3'h3;
            fire;
            chk_st(1'b1, 1'b0, 1'b1, (k == 0) ? 6'h05 : 6'h20);
        end
    endtask

    task automatic t_misc;
        wr(6'h00, 5'h00, 1'b0, round_nearest);
        {res_inexact, res_value} = {1'b1, 64'h4000_0000_0000_0001};
        fire;
        chk_st(1'b0, 1'b1, 1'b0, 6'h01);
        chk_v(dest_data, 64'h4000_0000_0000_0001);
        chk_v(64'(fp_exception_code), 64'h0);
        clr;
        op_kind = op_div;
        {opa_sign, opb_zero} = 2'h3;
        fire;
        chk_st(1'b0, 1'b1, 1'b0, 6'h08);
        chk_v(dest_data, DBL_INF | DBL_SIGN);
        chk_v(64'(flag_bits), 64'h09);
        clr;
        op_kind = op_mov;
        opa_snan = 1'b1;
        fire;
        chk_st(1'b0, 1'b1, 1'b0, 6'h00);
        wr(6'h00, 5'h10, 1'b0, round_nearest);
        for (int i = 0; i < 3; i++)
        begin
            clr;
            cvt_int_range_err = (i == 0);
            case (i)
                0: op_kind = op_cvt_int;
                1: opa_denorm = 1'b1;
                default: op_kind = op_reserved;
            endcase
            fire;
            chk_st(1'b1, 1'b0, 1'b1, 6'h20);
        end
    endtask

    task automatic test_done;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        compares = 0;
        miscompares = 0;
        rst_n = 1'b0;
        op_done = 1'b0;
        move_to_fp_control = 1'b0;
        {ctl_wr_cause, ctl_wr_enable, ctl_wr_flag, ctl_wr_flush} = '0;
        ctl_wr_rmode = round_nearest;
        clr;
        repeat (8) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        t_reset;
        t_invalid;
        t_range;
        t_misc;
        test_done;
    end
endmodule // fpuex_unit_tb_top
